// *** logic/crc_pkg.sv ***
// constants and types shared by the programmable crc control block
package crc_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] off_control_status = 8'h00;
    localparam logic [7:0] off_data_in        = 8'h04;
    localparam logic [7:0] off_polynomial     = 8'h08;
    localparam logic [7:0] off_result         = 8'h0c;
    localparam logic [7:0] off_irq_status     = 8'h10;
    localparam logic [7:0] off_irq_mask       = 8'h14;
    localparam int         addr_bits          = 8;

    // ---------------------------------------------------------------
    // control/status field positions
    // ---------------------------------------------------------------
    localparam int bit_idle_halt  = 13;
    localparam int bit_count_hi   = 12;
    localparam int bit_count_lo   = 8;
    localparam int bit_full       = 7;
    localparam int bit_empty      = 6;
    localparam int bit_run        = 4;
    localparam int bit_plen_hi    = 3;
    localparam int bit_plen_lo    = 0;

    // ---------------------------------------------------------------
    // reset values, depths and interrupt layout
    // ---------------------------------------------------------------
    localparam logic [3:0]  plen_reset      = 4'h0;
    localparam logic [15:0] poly_reset      = 16'h0000;
    localparam logic [15:0] seed_reset      = 16'h0000;
    localparam logic [3:0]  plen_wide_limit = 4'h7;
    localparam int          depth_wide      = 8;
    localparam int          depth_narrow    = 16;
    localparam int          word_bits       = 16;
    localparam int          irq_bits        = 3;
    localparam int          irq_word_done   = 0;
    localparam int          irq_drained     = 1;
    localparam int          irq_overflow    = 2;
    localparam logic [1:0]  htrans_nonseq   = 2'b10;
    localparam logic [1:0]  htrans_seq      = 2'b11;

    typedef enum logic {
        st_idle  = 1'b0,
        st_shift = 1'b1
    } shifter_state_t;
endpackage : crc_pkg

// *** logic/crc_word_fifo.sv ***
// input word fifo of the crc block
`timescale 1ns/1ps
module crc_word_fifo #(
    parameter int WIDTH = crc_pkg::word_bits,
    parameter int DEPTH = crc_pkg::depth_narrow
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic                       push,
    input  wire logic [WIDTH-1:0]           push_data,
    input  wire logic                       pop,
    output logic      [WIDTH-1:0]           pop_data,
    output logic      [$clog2(DEPTH):0]     count
);
    import crc_pkg::*;

    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_check
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;

    assign pop_data = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = wr_ptr + PW'(1);
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + PW'(1);
        end
        if (push && !pop) begin
            next_count = count + (PW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (PW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            mem[wr_ptr] <= push_data;
        end
    end
endmodule : crc_word_fifo

// *** logic/crc_serial_shifter.sv ***
// bit-serial crc shifter of programmable length
`timescale 1ns/1ps
module crc_serial_shifter #(
    parameter int WIDTH = crc_pkg::word_bits
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] word_in,
    input  wire logic [3:0]       plen,
    input  wire logic [WIDTH-1:0] poly,
    input  wire logic             seed_we,
    input  wire logic [WIDTH-1:0] seed,
    output logic      [WIDTH-1:0] crc,
    output logic                  busy,
    output logic                  done
);
    import crc_pkg::*;

    if (WIDTH != 16) begin : g_check
        $error("shifter width must be 16 to cover every length");
    end

    shifter_state_t   state;
    shifter_state_t   next_state;
    logic [3:0]       bit_cnt;
    logic [3:0]       next_bit_cnt;
    logic [WIDTH-1:0] shreg;
    logic [WIDTH-1:0] next_shreg;
    logic [WIDTH-1:0] next_crc;
    logic             next_done;
    logic [WIDTH-1:0] mask;
    logic             fb;

    always_comb begin
        mask = '0;
        for (int i = 0; i < WIDTH; i++) begin
            mask[i] = (i <= int'(plen));
        end
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_crc     = crc;
        next_done    = 1'b0;
        fb           = crc[plen] ^ shreg[plen];
        case (state)
            st_idle: begin
                if (seed_we) begin
                    next_crc = seed & mask;
                end
                if (start) begin
                    next_shreg   = word_in;
                    next_bit_cnt = plen;
                    next_state   = st_shift;
                end
            end
            st_shift: begin
                // register is plen+1 bits, feedback from its top bit
                next_crc   = ({crc[WIDTH-2:0], 1'b0} ^ (fb ? poly : '0))
                             & mask;
                next_shreg = {shreg[WIDTH-2:0], 1'b0};
                if (bit_cnt == 4'h0) begin
                    next_state = st_idle;
                    next_done  = 1'b1;
                end else begin
                    next_bit_cnt = bit_cnt - 4'h1;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state   <= st_idle;
            bit_cnt <= 4'h0;
            shreg   <= '0;
            crc     <= seed_reset;
            done    <= 1'b0;
        end else if (ce) begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            crc     <= next_crc;
            done    <= next_done;
        end
    end

    assign busy = (state == st_shift);
endmodule : crc_serial_shifter

// *** logic/programmable_crc_control.sv ***
// control, status and ahb-lite register file of the programmable crc
`timescale 1ns/1ps
//
// Contract
// - idle halt bit set: module suspends while device idles; clear: runs.
// - read-only five-bit field reports valid words held in the fifo.
// - fifo depth is 8 when length field exceeds 7, else 16.
// - full flag reads 1 while the fifo is full, else 0.
// - empty flag reads 1 while the fifo holds no words, else 0.
// - writing 1 to the run bit starts the shifter consuming fifo words.
// - run bit cleared: shifting continues until fifo drained, then stops.
// - length field holds polynomial length minus one.
module programmable_crc_control #(
    parameter int WIDTH = crc_pkg::word_bits,
    parameter int DEPTH = crc_pkg::depth_narrow
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 idle_mode,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire logic [31:0]          hwdata,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic                      irq,
    output logic                      shifter_active
);
    import crc_pkg::*;

    if (DEPTH != depth_narrow || WIDTH != word_bits) begin : g_check
        $error("fifo depth must be 16 and word width 16");
    end

    if (depth_wide > DEPTH) begin : g_depth_check
        $error("the long-polynomial depth must fit in the fifo");
    end

    localparam int CW = $clog2(DEPTH) + 1;

    // ---------------------------------------------------------------
    // bus address phase capture
    // ---------------------------------------------------------------
    logic                 dp_write;
    logic [addr_bits-1:0] dp_addr;
    logic                 next_dp_write;
    logic [addr_bits-1:0] next_dp_addr;
    logic                 take;

    assign take = hsel && hready && (htrans == htrans_nonseq ||
                                     htrans == htrans_seq);

    always_comb begin
        next_dp_write = take && hwrite;
        next_dp_addr  = take ? haddr[addr_bits-1:0] : dp_addr;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
        end else if (ce) begin
            dp_write <= next_dp_write;
            dp_addr  <= next_dp_addr;
        end
    end

    // ---------------------------------------------------------------
    // write strobes of the data phase
    // ---------------------------------------------------------------
    logic wr_poly;
    logic wr_seed;
    logic wr_irq_status;
    logic wr_irq_mask;

    assign wr_poly       = dp_write && dp_addr == off_polynomial;
    assign wr_seed       = dp_write && dp_addr == off_result;
    assign wr_irq_status = dp_write && dp_addr == off_irq_status;
    assign wr_irq_mask   = dp_write && dp_addr == off_irq_mask;

    // ---------------------------------------------------------------
    // fifo and shifter
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] pop_data;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;
    logic             halt;
    logic             run_ce;
    logic             sh_busy;
    logic             sh_done;
    logic [WIDTH-1:0] crc_value;
    logic             seed_we;
    logic [3:0]       plen;
    logic [WIDTH-1:0] poly;
    logic             idle_halt;
    logic             run;
    logic             full;
    logic             empty;
    logic [CW-1:0]    depth_sel;
    logic             wr_ctrl;
    logic             wr_data;

    // suspend all crc activity while idling with halt selected
    assign halt   = idle_halt && idle_mode;
    assign run_ce = ce && !halt;

    always_comb begin
        // depth halves when the polynomial is longer than 8 bits
        depth_sel = (plen > plen_wide_limit) ? CW'(depth_wide)
                                             : CW'(depth_narrow);
    end

    assign full    = (count == depth_sel);
    assign empty   = (count == '0);
    assign wr_ctrl = dp_write && dp_addr == off_control_status;
    assign wr_data = dp_write && dp_addr == off_data_in;
    assign push    = wr_data && !full && !halt;
    assign seed_we = wr_seed && !halt;
    // shifter takes a word while running or draining
    // a word leaves only while the shifter idles, so no load is lost
    assign pop     = !empty && !sh_busy && (run || shifter_active) && !halt;

    crc_word_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (run_ce || (ce && push)),
        .push      (push),
        .push_data (hwdata[WIDTH-1:0]),
        .pop       (pop),
        .pop_data  (pop_data),
        .count     (count)
    );

    crc_serial_shifter #(
        .WIDTH (WIDTH)
    ) u_shifter (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (run_ce),
        .start   (pop),
        .word_in (pop_data),
        .plen    (plen),
        .poly    (poly),
        .seed_we (seed_we),
        .seed    (hwdata[WIDTH-1:0]),
        .crc     (crc_value),
        .busy    (sh_busy),
        .done    (sh_done)
    );

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic             next_idle_halt;
    logic             next_run;
    logic [3:0]       next_plen;
    logic [WIDTH-1:0] next_poly;
    logic             next_active;

    // the length sets the fifo depth: change it only while the fifo is empty
    always_comb begin
        next_idle_halt = idle_halt;
        next_run       = run;
        next_plen      = plen;
        next_poly      = poly;
        next_active    = shifter_active;
        if (wr_ctrl) begin
            next_idle_halt = hwdata[bit_idle_halt];
            next_run       = hwdata[bit_run];
            next_plen      = hwdata[bit_plen_hi:bit_plen_lo];
        end
        if (wr_poly) begin
            next_poly = hwdata[WIDTH-1:0];
        end
        if (!halt) begin
            if (run) begin
                next_active = 1'b1;
            end else if (empty && !sh_busy && !pop) begin
                next_active = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idle_halt      <= 1'b0;
            run            <= 1'b0;
            plen           <= plen_reset;
            poly           <= poly_reset;
            shifter_active <= 1'b0;
        end else if (ce) begin
            idle_halt      <= next_idle_halt;
            run            <= next_run;
            plen           <= next_plen;
            poly           <= next_poly;
            shifter_active <= next_active;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    logic [irq_bits-1:0] irq_status;
    logic [irq_bits-1:0] irq_mask;
    logic [irq_bits-1:0] next_irq_status;
    logic [irq_bits-1:0] next_irq_mask;
    logic [irq_bits-1:0] irq_set;
    logic                next_irq;
    logic                overflow;
    logic                drained;

    // a word written while full is lost; while halted it is not flagged
    assign overflow = wr_data && full && !halt;
    assign drained  = shifter_active && !next_active;

    always_comb begin
        irq_set                = '0;
        irq_set[irq_word_done] = sh_done && !halt;
        irq_set[irq_drained]   = drained;
        irq_set[irq_overflow]  = overflow;
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (wr_irq_status) begin
            next_irq_status = irq_status & ~hwdata[irq_bits-1:0];
        end
        if (wr_irq_mask) begin
            next_irq_mask = hwdata[irq_bits-1:0];
        end
        // a new event outranks a clear in the same cycle
        next_irq_status = next_irq_status | irq_set;
        next_irq        = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_status <= '0;
            irq_mask   <= '0;
            irq        <= 1'b0;
        end else if (ce) begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            irq        <= next_irq;
        end
    end

    // ---------------------------------------------------------------
    // read data and response
    // ---------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic [31:0] next_hrdata;
    logic        rd_take;

    // read data stands for one data phase, then returns to zero
    assign rd_take = take && !hwrite;

    always_comb begin
        ctrl_word                           = '0;
        ctrl_word[bit_idle_halt]            = idle_halt;
        ctrl_word[bit_count_hi:bit_count_lo] = count;
        ctrl_word[bit_full]                 = full;
        ctrl_word[bit_empty]                = empty;
        ctrl_word[bit_run]                  = run;
        ctrl_word[bit_plen_hi:bit_plen_lo]  = plen;
        next_hrdata = '0;
        if (rd_take) begin
            case (haddr[addr_bits-1:0])
                off_control_status: next_hrdata = ctrl_word;
                off_polynomial:     next_hrdata = {16'h0000, poly};
                off_result:         next_hrdata = {16'h0000, crc_value};
                off_irq_status:     next_hrdata = {29'h0, irq_status};
                off_irq_mask:       next_hrdata = {29'h0, irq_mask};
                default:            next_hrdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:addr_bits], hwdata[31:16]};
endmodule : programmable_crc_control

// *** sim/crc_ctrl_assertions.sv ***
// assertions on the ports of the crc control block
`timescale 1ns/1ps
module crc_ctrl_checker
    import crc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        idle_mode,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        shifter_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----
    // bus phase tracking
    // ----
    logic       rd_dp;
    logic       wr_dp;
    logic       ctl_dp;
    logic       run_q;
    logic       halt_q;
    logic [3:0] plen_q;
    wire logic  take = ce & hsel & hready & htrans[1];
    wire logic  rd_ctl = rd_dp & ctl_dp;
    wire logic  wr_ctl = wr_dp & ctl_dp;
    wire logic [4:0] cnt = hrdata[12:8];
    wire logic [4:0] lim = (hrdata[3:0] > 4'h7) ? 5'h08 : 5'h10;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_dp  <= 1'b0;
            wr_dp  <= 1'b0;
            ctl_dp <= 1'b0;
            run_q  <= 1'b0;
            halt_q <= 1'b0;
            plen_q <= 4'h0;
        end else if (ce) begin
            rd_dp  <= take & !hwrite;
            wr_dp  <= take & hwrite;
            ctl_dp <= take & (haddr[7:0] == off_control_status);
            if (wr_ctl) begin
                run_q  <= hwdata[4];
                halt_q <= hwdata[13];
                plen_q <= hwdata[3:0];
            end
        end
    end
    // ----
    // properties
    // ----
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
    property p_idle; !rd_dp |-> hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stale read data");
    property p_count; rd_ctl |-> cnt <= lim; endproperty
    a_count: assert property (p_count) else $error("count too big");
    property p_full; rd_ctl |-> hrdata[7] == (cnt == lim); endproperty
    a_full: assert property (p_full)
        else $error("bad full");
    property p_empty; rd_ctl |-> hrdata[6] == (cnt == 5'h00); endproperty
    a_empty: assert property (p_empty) else $error("bad empty");
    property p_rw;
        rd_ctl |-> {hrdata[31:14], hrdata[5]} == 19'h0 &&
            {hrdata[13], hrdata[4], hrdata[3:0]} ==
            {$past(halt_q), $past(run_q), $past(plen_q)};
    endproperty
    a_rw: assert property (p_rw) else $error("bad control bits");
    property p_reset;
        $fell(rst) |-> hrdata == 32'h0 && !shifter_active;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset");
    property p_halt;
        halt_q && idle_mode && !wr_ctl |=> $stable(shifter_active);
    endproperty
    a_halt: assert property (p_halt) else $error("ran while halted");
    property p_start;
        $rose(shifter_active) |-> $past(run_q);
    endproperty
    a_start: assert property (p_start) else $error("start w/o run");
    property p_stop;
        $fell(shifter_active) |-> !$past(run_q);
    endproperty
    a_stop: assert property (p_stop) else $error("stop with run");
    c_full: cover property (rd_ctl && hrdata[7]);
    c_halt: cover property (halt_q && idle_mode && shifter_active);
    c_drain: cover property ($fell(shifter_active));
endmodule : crc_ctrl_checker

bind programmable_crc_control crc_ctrl_checker chk_i (
    .sys_clk, .rst, .ce, .idle_mode, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .shifter_active);

// *** sim/programmable_crc_control_tb.sv ***
// self-checking bench for the programmable crc control block
`timescale 1ns/1ps
module programmable_crc_control_tb;
    import crc_pkg::*;
    logic        sys_clk, rst, ce, idle_mode, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire logic [31:0] hrdata;
    wire logic   hready, hresp, irq, shifter_active;
    int          mismatches, n_compared;

    programmable_crc_control uut (
        .sys_clk, .rst, .ce, .idle_mode, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp,
        .irq, .shifter_active);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ----
    // helpers
    // ----
    task automatic chk(input string what, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk

    task automatic wait_ready;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
    endtask : wait_ready

    // one single transfer; read data lands in rd
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= htrans_nonseq;
        wait_ready;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        wait_ready;
        rd = hrdata;
    endtask : xfer

    task automatic wait_idle;
        for (int n = 0; n < 600 && shifter_active !== 1'b0; n++)
            @(posedge sys_clk);
        chk("active", 32'h0, {31'h0, shifter_active});
    endtask : wait_idle

    function automatic logic [31:0] ctl_exp(input int c,
        input logic [3:0] pl, input logic run, halt);
        int dep;
        dep = (pl > plen_wide_limit) ? depth_wide : depth_narrow;
        return {18'h0, halt, c[4:0], c == dep, c == 0, 1'b0, run, pl};
    endfunction : ctl_exp

    function automatic logic [15:0] fold(input logic [3:0] pl,
                                         input logic [15:0] p, d);
        logic [15:0] c;
        logic [15:0] m;
        c = 16'h0;
        m = 16'hffff >> (4'hf - pl);
        for (int b = pl; b >= 0; b--)
            c = ((c << 1) ^ ((c[pl] ^ d[b]) ? p : 16'h0)) & m;
        return c;
    endfunction : fold
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        xfer(1'b0, off_control_status, 32'h0);
        chk("ctl", 32'h0000_0040, rd);
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, 8'h20, 32'hffff_ffff);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(1'b1, off_control_status, 32'h0000_ffc0);
        xfer(1'b0, off_control_status, 32'h0);
        chk("ctl", ctl_exp(0, 4'h0, 1'b0, 1'b1), rd);
        xfer(1'b1, off_control_status, 32'h0);
    endtask : t_reset

    task automatic t_fill(input logic [3:0] pl);
        int dep;
        int n;
        dep = (pl > plen_wide_limit) ? depth_wide : depth_narrow;
        xfer(1'b1, off_control_status, {28'h0, pl});
        for (int i = 1; i <= dep + 1; i++) begin
            xfer(1'b1, off_data_in, 32'(i));
            xfer(1'b0, off_control_status, 32'h0);
            n = (i > dep) ? dep : i;
            chk("ctl", ctl_exp(n, pl, 1'b0, 1'b0), rd);
        end
        xfer(1'b0, off_irq_status, 32'h0);
        chk("overflow", 32'h4, rd & 32'h4);
        xfer(1'b1, off_irq_mask, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h1, {31'h0, irq});
        xfer(1'b1, off_irq_status, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, off_control_status, {27'h0, 1'b1, pl});
        xfer(1'b1, off_control_status, {28'h0, pl});
        chk("active", 32'h1, {31'h0, shifter_active});
        wait_idle;
        xfer(1'b0, off_control_status, 32'h0);
        chk("ctl", ctl_exp(0, pl, 1'b0, 1'b0), rd);
        xfer(1'b0, off_irq_status, 32'h0);
        chk("drained", 32'h2, rd & 32'h2);
    endtask : t_fill

    task automatic t_crc(input logic [3:0] pl, input logic [15:0] p, d);
        xfer(1'b1, off_control_status, {28'h0, pl});
        xfer(1'b1, off_polynomial, {16'h0, p});
        xfer(1'b1, off_result, 32'h0);
        xfer(1'b1, off_data_in, {16'h0, d});
        xfer(1'b1, off_control_status, {27'h0, 1'b1, pl});
        xfer(1'b1, off_control_status, {28'h0, pl});
        wait_idle;
        xfer(1'b0, off_result, 32'h0);
        chk("crc", {16'h0, fold(pl, p, d)}, rd);
    endtask : t_crc

    task automatic t_idle;
        xfer(1'b1, off_control_status, 32'h0000_2000);
        xfer(1'b1, off_data_in, 32'h1);
        xfer(1'b1, off_data_in, 32'h2);
        idle_mode <= 1'b1;
        xfer(1'b1, off_control_status, 32'h0000_2010);
        repeat (20) @(posedge sys_clk);
        xfer(1'b1, off_data_in, 32'h3);
        xfer(1'b0, off_control_status, 32'h0);
        chk("ctl", ctl_exp(2, 4'h0, 1'b1, 1'b1), rd);
        xfer(1'b1, off_control_status, 32'h0000_0010);
        xfer(1'b1, off_control_status, 32'h0);
        wait_idle;
        xfer(1'b0, off_control_status, 32'h0);
        chk("ctl", ctl_exp(0, 4'h0, 1'b0, 1'b0), rd);
        idle_mode <= 1'b0;
    endtask : t_idle

    task automatic tally_and_finish;
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        idle_mode = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        mismatches = 0;
        n_compared = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        t_fill(4'h7);
        t_fill(4'h8);
        t_crc(4'h3, 16'h0003, 16'h000b);
        t_crc(4'hf, 16'h1021, 16'hbeef);
        t_idle;
        tally_and_finish;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish;
    end
endmodule : programmable_crc_control_tb
